// ==== rtl/dprw_mem.sv ====
`timescale 1ns/10ps
// storage array with two write ports
module dprw_mem #(
  parameter logic [1:0] VARIANT = dprw_pkg::DPRW_9K
) (
  input  wire logic                        clk,
  input  wire logic                        ce,
  input  wire logic                        we_a,
  input  wire logic                        we_b,
  input  wire logic [dprw_pkg::ADDR_W-1:0] addr_a,
  input  wire logic [dprw_pkg::ADDR_W-1:0] addr_b,
  input  wire logic [dprw_pkg::DATA_W-1:0] wdata_a,
  input  wire logic [dprw_pkg::DATA_W-1:0] wdata_b,
  output logic      [dprw_pkg::DATA_W-1:0] rdata_a,
  output logic      [dprw_pkg::DATA_W-1:0] rdata_b
);

  logic [dprw_pkg::DATA_W-1:0] mem [dprw_pkg::DEPTH];

  // 144k array starts with a non-zero pattern standing for undefined
  initial begin
    for (int i = 0; i < dprw_pkg::DEPTH; i++) begin
      mem[i] = (VARIANT == dprw_pkg::DPRW_144K) ?
               dprw_pkg::DATA_UNDEF : dprw_pkg::DATA_RST;
    end
  end

  assign rdata_a = mem[addr_a];
  assign rdata_b = mem[addr_b];

  // port b write after port a; same-address collision left to user logic
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we_a) begin
        mem[addr_a] <= wdata_a;
      end
      if (we_b) begin
        mem[addr_b] <= wdata_b;
      end
    end
  end

endmodule : dprw_mem

// ==== rtl/dprw_pkg.sv ====
// shared constants and types for the dual-port ram block
package dprw_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int DEPTH  = 256;

  typedef enum logic [1:0] {
    DPRW_NEW_DATA,
    DPRW_OLD_DATA,
    DPRW_DONT_CARE
  } dprw_rdw_e;

  typedef enum logic [1:0] {
    DPRW_LUT,
    DPRW_9K,
    DPRW_144K
  } dprw_var_e;

  localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_UNDEF = 16'hDEAD;

endpackage : dprw_pkg

// ==== rtl/dprw_port.sv ====
`timescale 1ns/10ps
// one port's read path: read-during-write select and output register
module dprw_port (
  input  wire logic                        clk,
  input  wire logic                        ce,
  input  wire logic                        clr,
  input  wire logic                        rd_en,
  input  wire logic                        rdw_same,
  input  wire logic                        rdw_mixed,
  input  wire logic [1:0]                  same_mode,
  input  wire logic [1:0]                  mixed_mode,
  input  wire logic [dprw_pkg::DATA_W-1:0] old_word,
  input  wire logic [dprw_pkg::DATA_W-1:0] own_wdata,
  input  wire logic [dprw_pkg::DATA_W-1:0] other_wdata,
  output logic      [dprw_pkg::DATA_W-1:0] q_raw,
  output logic      [dprw_pkg::DATA_W-1:0] q_reg
);

  logic [dprw_pkg::DATA_W-1:0] sel_nxt;

  // pick read value for this cycle
  always_comb begin
    sel_nxt = old_word;
    if (rdw_same) begin
      unique case (same_mode)
        dprw_pkg::DPRW_NEW_DATA:  sel_nxt = own_wdata;
        dprw_pkg::DPRW_OLD_DATA:  sel_nxt = old_word;
        default:                  sel_nxt = dprw_pkg::DATA_UNDEF;
      endcase
    end else if (rdw_mixed) begin
      unique case (mixed_mode)
        dprw_pkg::DPRW_NEW_DATA:  sel_nxt = other_wdata;
        dprw_pkg::DPRW_OLD_DATA:  sel_nxt = old_word;
        default:                  sel_nxt = dprw_pkg::DATA_UNDEF;
      endcase
    end
  end

  // read latch: held when read disabled
  always_ff @(posedge clk) begin
    if (clr) begin
      q_raw <= dprw_pkg::DATA_RST;
    end else if (ce && rd_en) begin
      q_raw <= sel_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      q_reg <= dprw_pkg::DATA_RST;
    end else if (ce) begin
      q_reg <= q_raw;
    end
  end

endmodule : dprw_port

// ==== rtl/dprw_top.sv ====
`timescale 1ns/10ps
// single-clock true dual-port ram with read-during-write modes
module dprw_top #(
  parameter logic [1:0] VARIANT    = dprw_pkg::DPRW_9K,
  parameter logic [1:0] SAME_MODE  = dprw_pkg::DPRW_NEW_DATA,
  parameter logic [1:0] MIXED_MODE = dprw_pkg::DPRW_OLD_DATA,
  parameter bit         OUT_REG    = 1'b1
) (
  input  wire logic                        CLOCK_IN,
  input  wire logic                        RST_IN,
  input  wire logic                        CE_IN,
  input  wire logic                        WE_A_IN,
  input  wire logic                        RD_EN_A_IN,
  input  wire logic [dprw_pkg::ADDR_W-1:0] ADDR_A_IN,
  input  wire logic [dprw_pkg::DATA_W-1:0] DATA_A_IN,
  input  wire logic                        WE_B_IN,
  input  wire logic                        RD_EN_B_IN,
  input  wire logic [dprw_pkg::ADDR_W-1:0] ADDR_B_IN,
  input  wire logic [dprw_pkg::DATA_W-1:0] DATA_B_IN,
  output logic      [dprw_pkg::DATA_W-1:0] Q_A_OUT,
  output logic      [dprw_pkg::DATA_W-1:0] Q_B_OUT
);

  // static mode resolution; lut forces same-port don't care
  localparam bit IS_LUT = (VARIANT == dprw_pkg::DPRW_LUT);
  localparam logic [1:0] SAME_EFF =
    IS_LUT ? dprw_pkg::DPRW_DONT_CARE : SAME_MODE;
  localparam logic [1:0] MIXED_EFF =
    (!IS_LUT && MIXED_MODE == dprw_pkg::DPRW_NEW_DATA) ?
    dprw_pkg::DPRW_OLD_DATA : MIXED_MODE;

  // input registers; lut address regs model adjacent general logic
  logic                        we_a_r;
  logic                        we_b_r;
  logic                        rd_a_r;
  logic                        rd_b_r;
  logic [dprw_pkg::ADDR_W-1:0] addr_a_r;
  logic [dprw_pkg::ADDR_W-1:0] addr_b_r;
  logic [dprw_pkg::DATA_W-1:0] data_a_r;
  logic [dprw_pkg::DATA_W-1:0] data_b_r;
  logic                        ce_r;

  // address registers are not cleared by the clear
  always_ff @(posedge CLOCK_IN) begin
    if (CE_IN) begin
      addr_a_r <= ADDR_A_IN;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (CE_IN) begin
      addr_b_r <= ADDR_B_IN;
    end
  end

  // data-in registers sit inside the block on every variant
  always_ff @(posedge CLOCK_IN) begin
    if (CE_IN) begin
      data_a_r <= DATA_A_IN;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (CE_IN) begin
      data_b_r <= DATA_B_IN;
    end
  end

  // shared enable delayed to the array and read stages
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      ce_r <= 1'b0;
    end else begin
      ce_r <= CE_IN;
    end
  end

  // write enables cleared so no stray write follows reset
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      we_a_r <= 1'b0;
    end else if (CE_IN) begin
      we_a_r <= WE_A_IN;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      we_b_r <= 1'b0;
    end else if (CE_IN) begin
      we_b_r <= WE_B_IN;
    end
  end

  // read enables; a low one freezes that port's read latch
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      rd_a_r <= 1'b0;
    end else if (CE_IN) begin
      rd_a_r <= RD_EN_A_IN;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      rd_b_r <= 1'b0;
    end else if (CE_IN) begin
      rd_b_r <= RD_EN_B_IN;
    end
  end

  logic [dprw_pkg::DATA_W-1:0] rdata_a;
  logic [dprw_pkg::DATA_W-1:0] rdata_b;
  logic                        mixed_a;
  logic                        mixed_b;
  logic                        ce_act;

  // a port collides when the other port writes the word it addresses
  function automatic logic collide(
    input logic                        wr,
    input logic [dprw_pkg::ADDR_W-1:0] own_addr,
    input logic [dprw_pkg::ADDR_W-1:0] wr_addr
  );
    return wr && (own_addr == wr_addr);
  endfunction : collide

  assign mixed_a = collide(we_b_r, addr_a_r, addr_b_r);
  assign mixed_b = collide(we_a_r, addr_b_r, addr_a_r);
  assign ce_act  = ce_r;

  dprw_mem #(
    .VARIANT (VARIANT)
  ) u_mem (
    .clk     (CLOCK_IN),
    .ce      (ce_act),
    .we_a    (we_a_r),
    .we_b    (we_b_r),
    .addr_a  (addr_a_r),
    .addr_b  (addr_b_r),
    .wdata_a (data_a_r),
    .wdata_b (data_b_r),
    .rdata_a (rdata_a),
    .rdata_b (rdata_b)
  );

  logic [dprw_pkg::DATA_W-1:0] q_a_raw;
  logic [dprw_pkg::DATA_W-1:0] q_a_reg;
  logic [dprw_pkg::DATA_W-1:0] q_b_raw;
  logic [dprw_pkg::DATA_W-1:0] q_b_reg;

  // same-port collision on a write; mixed when other port writes our address
  dprw_port u_port_a (
    .clk         (CLOCK_IN),
    .ce          (ce_act),
    .clr         (RST_IN),
    .rd_en       (rd_a_r),
    .rdw_same    (we_a_r),
    .rdw_mixed   (mixed_a),
    .same_mode   (SAME_EFF),
    .mixed_mode  (MIXED_EFF),
    .old_word    (rdata_a),
    .own_wdata   (data_a_r),
    .other_wdata (data_b_r),
    .q_raw       (q_a_raw),
    .q_reg       (q_a_reg)
  );

  dprw_port u_port_b (
    .clk         (CLOCK_IN),
    .ce          (ce_act),
    .clr         (RST_IN),
    .rd_en       (rd_b_r),
    .rdw_same    (we_b_r),
    .rdw_mixed   (mixed_b),
    .same_mode   (SAME_EFF),
    .mixed_mode  (MIXED_EFF),
    .old_word    (rdata_b),
    .own_wdata   (data_b_r),
    .other_wdata (data_a_r),
    .q_raw       (q_b_raw),
    .q_reg       (q_b_reg)
  );

  // output register use is static; bypass shows the read latch
  logic [dprw_pkg::DATA_W-1:0] q_a_sel;
  logic [dprw_pkg::DATA_W-1:0] q_b_sel;

  always_comb begin
    q_a_sel = q_a_raw;
    if (OUT_REG) begin
      q_a_sel = q_a_reg;
    end
  end

  always_comb begin
    q_b_sel = q_b_raw;
    if (OUT_REG) begin
      q_b_sel = q_b_reg;
    end
  end

  // outputs from flops; cleared under reset
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      Q_A_OUT <= dprw_pkg::DATA_RST;
    end else begin
      Q_A_OUT <= q_a_sel;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      Q_B_OUT <= dprw_pkg::DATA_RST;
    end else begin
      Q_B_OUT <= q_b_sel;
    end
  end

endmodule : dprw_top

// ==== verification/dprw_sva.sv ====
// concurrent checks on the dual-port ram ports
`timescale 1ns/10ps
module dprw_sva (
  input wire logic CLOCK_IN, RST_IN, CE_IN, WE_A_IN, RD_EN_A_IN,
  input wire logic WE_B_IN, RD_EN_B_IN,
  input wire logic [dprw_pkg::ADDR_W-1:0] ADDR_A_IN, ADDR_B_IN,
  input wire logic [dprw_pkg::DATA_W-1:0] DATA_A_IN, DATA_B_IN,
  input wire logic [dprw_pkg::DATA_W-1:0] Q_A_OUT, Q_B_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  property p_rst;
    disable iff (1'b0) RST_IN |=> Q_A_OUT == 16'h0000 && Q_B_OUT == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("q not cleared");
  property p_rel;
    $fell(RST_IN) |-> (Q_A_OUT == 16'h0000 && Q_B_OUT == 16'h0000) [*3];
  endproperty
  a_rel: assert property (p_rel) else $error("q not zero");
  property p_ce;
    !CE_IN [*2] |-> ##2 ($stable(Q_A_OUT) && $stable(Q_B_OUT));
  endproperty
  a_ce: assert property (p_ce) else $error("q moved");
  property p_new_a;
    WE_A_IN && RD_EN_A_IN && CE_IN ##1 CE_IN
      |-> ##3 Q_A_OUT == $past(DATA_A_IN, 4);
  endproperty
  a_new_a: assert property (p_new_a) else $error("q_a not new");
  property p_new_b;
    WE_B_IN && RD_EN_B_IN && CE_IN ##1 CE_IN
      |-> ##3 Q_B_OUT == $past(DATA_B_IN, 4);
  endproperty
  a_new_b: assert property (p_new_b) else $error("q_b not new");
  property p_mix;
    WE_A_IN && CE_IN && !(WE_B_IN && ADDR_B_IN == ADDR_A_IN)
      ##1 WE_A_IN && CE_IN && RD_EN_B_IN && !WE_B_IN &&
      ADDR_B_IN == ADDR_A_IN && $stable(ADDR_A_IN) ##1 CE_IN
      |-> ##3 Q_B_OUT == $past(DATA_A_IN, 5);
  endproperty
  a_mix: assert property (p_mix) else $error("q_b not old");
  property p_rden_a;
    (!RD_EN_A_IN && CE_IN) [*4] |=> $stable(Q_A_OUT);
  endproperty
  a_rden_a: assert property (p_rden_a) else $error("q_a moved");
  property p_rden_b;
    (!RD_EN_B_IN && CE_IN) [*4] |=> $stable(Q_B_OUT);
  endproperty
  a_rden_b: assert property (p_rden_b) else $error("q_b moved");
  c_wr: cover property (WE_A_IN && RD_EN_A_IN && CE_IN);
  c_ce: cover property (!CE_IN [*2]);
  c_rst: cover property ($fell(RST_IN));
endmodule : dprw_sva
bind dprw_top dprw_sva dprw_sva_i (.*);

// ==== verification/dprw_user.sv ====
// user logic model driving both ram ports
`timescale 1ns/10ps
module dprw_user (
  input  wire logic clk_in, // sole request clock
  output logic      ce_out, we_a_out, rd_a_out, we_b_out, rd_b_out,
  output logic      [dprw_pkg::ADDR_W-1:0] ad_a_out, ad_b_out,
  output logic      [dprw_pkg::DATA_W-1:0] d_a_out, d_b_out
);
  initial begin
    ce_out = 1'b1;
    {we_a_out, rd_a_out, we_b_out, rd_b_out} = 4'h0;
    {ad_a_out, ad_b_out, d_a_out, d_b_out} = '0;
  end
  task automatic put(
    input logic                        c, wa, ra,
    input logic [dprw_pkg::ADDR_W-1:0] aa,
    input logic [dprw_pkg::DATA_W-1:0] da,
    input logic                        wb, rb,
    input logic [dprw_pkg::ADDR_W-1:0] ab,
    input logic [dprw_pkg::DATA_W-1:0] db);
    @(posedge clk_in);
    #5;
    ce_out = c;
    {we_a_out, rd_a_out, ad_a_out, d_a_out} = {wa, ra, aa, da};
    we_b_out = wb && !(wa && aa == ab); // no double write
    {rd_b_out, ad_b_out, d_b_out} = {rb, ab, db};
  endtask : put
  task automatic rest();
    put(1'b1, 1'b0, 1'b0, 8'h00, 16'h0000,
        1'b0, 1'b0, 8'h00, 16'h0000); // reads off when idle
    repeat (3) @(posedge clk_in);
    #5;
  endtask : rest
endmodule : dprw_user

// ==== verification/test_dprw_top.sv ====
// testbench for the dual-port ram block
`timescale 1ns/10ps
module test_dprw_top;
  logic CLOCK_IN = 1'b0;
  logic RST_IN = 1'b1;
  logic CE_IN, WE_A_IN, RD_EN_A_IN, WE_B_IN, RD_EN_B_IN;
  logic [dprw_pkg::ADDR_W-1:0] ADDR_A_IN, ADDR_B_IN;
  logic [dprw_pkg::DATA_W-1:0] DATA_A_IN, DATA_B_IN, Q_A_OUT, Q_B_OUT;
  int   num_errors = 0;
  int   tests_run = 0;
  always #25 CLOCK_IN = ~CLOCK_IN;
  dprw_top dprw_top_i (.*);
  dprw_user dprw_user_i (.clk_in(CLOCK_IN), .ce_out(CE_IN),
    .we_a_out(WE_A_IN), .rd_a_out(RD_EN_A_IN), .ad_a_out(ADDR_A_IN),
    .d_a_out(DATA_A_IN), .we_b_out(WE_B_IN), .rd_b_out(RD_EN_B_IN),
    .ad_b_out(ADDR_B_IN), .d_b_out(DATA_B_IN));
  task automatic chk(input string nm,
                     input logic [dprw_pkg::DATA_W-1:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge CLOCK_IN);
    #5;
    RST_IN = 1'b0;
    chk("q_a power-up", 16'h0000, Q_A_OUT);
    dprw_user_i.put(1'b1, 1'b1, 1'b1, 8'h05, 16'h1234,
                    1'b1, 1'b1, 8'h06, 16'h5678);
    // a overwrites while b reads that word
    dprw_user_i.put(1'b1, 1'b1, 1'b0, 8'h05, 16'hABCD,
                    1'b0, 1'b1, 8'h05, 16'h0000);
    dprw_user_i.rest();
    chk("q_a new", 16'h1234, Q_A_OUT);
    chk("q_b old", 16'h1234, Q_B_OUT);
    repeat (2) dprw_user_i.put(1'b0, 1'b1, 1'b1, 8'h07, 16'h1111,
                               1'b0, 1'b1, 8'h05, 16'h0000);
    dprw_user_i.rest();
    chk("q_b frozen", 16'h1234, Q_B_OUT);
    dprw_user_i.put(1'b1, 1'b0, 1'b1, 8'h07, 16'h0000,
                    1'b0, 1'b0, 8'h00, 16'h0000);
    dprw_user_i.rest();
    chk("q_a blank", 16'h0000, Q_A_OUT);
    @(posedge CLOCK_IN);
    #5;
    RST_IN = 1'b1;
    repeat (2) @(posedge CLOCK_IN);
    #5;
    chk("q_b reset", 16'h0000, Q_B_OUT);
    RST_IN = 1'b0;
    dprw_user_i.put(1'b1, 1'b0, 1'b1, 8'h05, 16'h0000,
                    1'b0, 1'b1, 8'h06, 16'h0000);
    dprw_user_i.rest();
    chk("q_a kept", 16'hABCD, Q_A_OUT);
    chk("q_b kept", 16'h5678, Q_B_OUT);
    tally_and_finish();
  end
  // far beyond the roughly 45 cycles the sequence takes
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule : test_dprw_top
